// ---- include/pwl_pkg.sv ----
package pwl_pkg;
  // switch, rate and address widths
  localparam int SW_W = 4;
  localparam int RATE_W = 3;
  localparam int ADDR_W = 7;
  // bit-rate codes, equal to the upper switch position in rate mode
  localparam logic [2:0] RATE_10K = 3'h0;
  localparam logic [2:0] RATE_20K = 3'h1;
  localparam logic [2:0] RATE_50K = 3'h2;
  localparam logic [2:0] RATE_125K = 3'h3;
  localparam logic [2:0] RATE_250K = 3'h4;
  localparam logic [2:0] RATE_500K = 3'h5;
  localparam logic [2:0] RATE_800K = 3'h6;
  localparam logic [2:0] RATE_1M = 3'h7;
  localparam logic [2:0] RATE_DEFAULT = RATE_1M;
  // switch decode limits
  localparam logic [3:0] LOWER_DIGIT_MAX = 4'h9;
  localparam logic [3:0] UPPER_RATE_MAX = 4'h7;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'h7f;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_SWITCH = 8'h08;
  localparam logic [7:0] REG_CONFIG = 8'h0c;
  // register fields and reset values
  localparam int CTRL_WREN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int STS_STATE_LSB = 0;
  localparam int STS_RATE_MODE = 4;
  localparam int STS_ADDR_OK = 5;
  localparam int STS_COMM_EN = 6;
  localparam int STS_NV_WROTE = 7;
  localparam int STS_DONE = 8;
  localparam int STS_RATE_KEPT = 9;
  localparam int SWR_LOWER_LSB = 0;
  localparam int SWR_UPPER_LSB = 4;
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_ADDR_LSB = 8;
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  // power-up sequence states, gray along the path through write; check to run flips two bits
  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_LATCH = 3'h1,
    ST_CHECK = 3'h3,
    ST_WRITE = 3'h2,
    ST_RUN = 3'h6
  } pwl_state_t;

  // upper * 10 + lower without a multiplier
  function automatic logic [7:0] pwl_node_addr(input logic [3:0] up, input logic [3:0] lo);
    pwl_node_addr = 8'({up, 3'h0}) + 8'({up, 1'h0}) + 8'(lo);
  endfunction : pwl_node_addr
endpackage : pwl_pkg

// ---- tb/pwl_loader_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwl_loader_props
  import pwl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // store link
  input wire logic nv_blank_i,
  input wire logic [RATE_W-1:0] nv_rate_i,
  input wire logic nv_done_i,
  input wire logic nv_wr_o,
  input wire logic [RATE_W-1:0] nv_wdata_o,
  // configuration
  input wire logic [RATE_W-1:0] can_rate_o,
  input wire logic [ADDR_W-1:0] node_addr_o,
  input wire logic can_enable_o,
  input wire logic cfg_done_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // write request waiting for the store
  sequence s_wr_wait;
    nv_wr_o && !nv_done_i ##1 nv_wr_o && $stable(nv_wdata_o);
  endsequence
  // store answered: request drops and the new rate goes live
  sequence s_wr_finish;
    nv_wr_o && nv_done_i ##1 !nv_wr_o && cfg_done_o && can_rate_o == $past(nv_wdata_o);
  endsequence
  a_done_sticky: assert property (
    cfg_done_o |=> cfg_done_o) else $error("done flag dropped");
  a_cfg_frozen: assert property (
    cfg_done_o |=> $stable(can_rate_o) && $stable(node_addr_o) && $stable(can_enable_o))
    else $error("configuration moved after done");
  a_seq_time: assert property (
    $fell(rst_i) |-> ##3 (nv_wr_o || cfg_done_o)) else $error("sequence late");
  a_wr_hold: assert property (
    nv_wr_o && !nv_done_i |-> s_wr_wait) else $error("write request not held");
  a_wr_finish: assert property (
    nv_wr_o && nv_done_i |-> s_wr_finish) else $error("write completion wrong");
  a_wr_differs: assert property (
    $rose(nv_wr_o) |-> nv_wdata_o != (nv_blank_i ? RATE_DEFAULT : nv_rate_i))
    else $error("store rewritten with same rate");
  a_wr_quiet: assert property (
    nv_wr_o |-> !can_enable_o && !cfg_done_o) else $error("bus enabled while writing");
  a_en_addr: assert property (
    can_enable_o |-> node_addr_o != 7'h00 && cfg_done_o) else $error("enabled with bad address");
endmodule : pwl_loader_props
bind pwl_loader pwl_loader_props u_props (
  .clk_sys_i(clk_sys_i),
  .rst_i(rst_i),
  .nv_blank_i(nv_blank_i),
  .nv_rate_i(nv_rate_i),
  .nv_done_i(nv_done_i),
  .nv_wr_o(nv_wr_o),
  .nv_wdata_o(nv_wdata_o),
  .can_rate_o(can_rate_o),
  .node_addr_o(node_addr_o),
  .can_enable_o(can_enable_o),
  .cfg_done_o(cfg_done_o)
);
`default_nettype wire

// ---- tb/pwl_loader_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwl_loader_tb
  import pwl_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic slow = 1'b0;
  logic [3:0] sw_up = 4'h0, sw_lo = 4'h0;
  logic nv_blank, nv_done, nv_wr, can_en, done, hready, hwrite = 1'b0;
  logic [2:0] nv_rate, nv_wdata, can_rate;
  logic [2:0] st = 3'h7;
  logic [6:0] node;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q0;
  logic [1:0] htrans = 2'h0;
  logic [1:0] hresp;
  int miscompares = 0, checked = 0, cyc = 0, nwr = 0;
  // address sweep: 127, 128, 0, 1, 159
  localparam logic [7:0] ADR_TAB [5] = '{8'hc7, 8'hc8, 8'h00, 8'h01, 8'hf9};
  pwl_loader dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sw_upper_i(sw_up), .sw_lower_i(sw_lo),
    .nv_blank_i(nv_blank), .nv_rate_i(nv_rate), .nv_done_i(nv_done), .nv_wr_o(nv_wr),
    .nv_wdata_o(nv_wdata), .can_rate_o(can_rate), .node_addr_o(node),
    .can_enable_o(can_en), .cfg_done_o(done), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp)
  );
  pwl_nv_model nv (
    .clk_sys_i(clk_sys_i), .slow_i(slow), .nv_wr_i(nv_wr), .nv_wdata_i(nv_wdata),
    .nv_blank_o(nv_blank), .nv_rate_o(nv_rate), .nv_done_o(nv_done)
  );
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // completed store writes and a hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (nv_wr === 1'b1 && nv_done === 1'b1) nwr <= nwr + 1;
    if (cyc == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one single AHB-Lite transfer; entered just after a rising edge
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    q = hrdata;
  endtask : ahb
  // one power-up with the given switches, then checks with switches moved
  task automatic run(input logic [3:0] u, input logic [3:0] l);
    logic rm, wr;
    logic [7:0] ad;
    logic [31:0] q;
    int n0;
    rm = l > LOWER_DIGIT_MAX;
    ad = 8'(u) * 8'd10 + 8'(l);
    wr = rm && u <= UPPER_RATE_MAX && u[2:0] != st;
    if (rm && u <= UPPER_RATE_MAX) st = u[2:0];
    n0 = nwr;
    slow <= ~slow;
    sw_up <= u;
    sw_lo <= l;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 60 && done !== 1'b1; i++) @(posedge clk_sys_i);
    sw_up <= ~u;
    sw_lo <= ~l;
    repeat (4) @(posedge clk_sys_i);
    chk("done", done, 1);
    chk("rate", can_rate, st);
    chk("addr", node, ad[6:0]);
    chk("enable", can_en, !rm && ad >= ADDR_MIN && ad <= ADDR_MAX);
    chk("writes", nwr - n0, wr);
    ahb(REG_SWITCH, 1'b0, 32'h0, q);
    chk("switch reg", q, {24'h0, u, l});
    ahb(REG_CONFIG, 1'b0, 32'h0, q);
    chk("config reg", q, {17'h0, ad[6:0], 5'h0, st});
    // status word: run state, mode, validity, store write and kept-rate flags
    ahb(REG_STATUS, 1'b0, 32'h0, q);
    chk("status reg", q, {22'h0, rm && u > UPPER_RATE_MAX, 1'b1, wr,
        !rm && ad >= ADDR_MIN && ad <= ADDR_MAX, !rm && ad >= ADDR_MIN && ad <= ADDR_MAX,
        rm, 1'b0, 3'(ST_RUN)});
    chk("resp", {30'h0, hresp}, {30'h0, HRESP_OKAY});
  endtask : run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence: blank store, rate changes, repeats, codes, address edges
  initial begin
    run(4'h2, 4'h5);
    ahb(REG_CTRL, 1'b0, 32'h0, q0);
    chk("ctrl reset", q0, CTRL_RESET);
    ahb(REG_CTRL, 1'b1, 32'h0, q0);
    ahb(REG_CTRL, 1'b0, 32'h0, q0);
    chk("ctrl write", q0, 32'h0);
    ahb(8'h10, 1'b0, 32'h0, q0);
    chk("unmapped", q0, 32'h0);
    run(4'h3, 4'ha);
    run(4'h3, 4'hf);
    run(4'h9, 4'hb);
    for (int c = 0; c < 8; c++) run(4'(c), 4'hc);
    for (int i = 0; i < 5; i++) run(ADR_TAB[i][7:4], ADR_TAB[i][3:0]);
    tally_and_finish();
  end
endmodule : pwl_loader_tb
`default_nettype wire

// ---- tb/pwl_nv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwl_nv_model (
  // clock
  input wire logic clk_sys_i,
  // latency select, high adds wait cycles
  input wire logic slow_i,
  // store link
  input wire logic nv_wr_i,
  input wire logic [2:0] nv_wdata_i,
  output logic nv_blank_o,
  output logic [2:0] nv_rate_o,
  output logic nv_done_o
);
  logic [2:0] wait_r;
  // blank store holds junk, so a loader that ignores the blank flag shows up
  initial begin
    nv_blank_o = 1'b1;
    nv_rate_o = 3'h2;
    nv_done_o = 1'b0;
    wait_r = 3'h0;
  end
  // no reset input: contents must survive every power cycle
  always @(posedge clk_sys_i) begin
    nv_done_o <= 1'b0;
    if (nv_wr_i === 1'b1 && !nv_done_o) begin
      wait_r <= wait_r + 3'h1;
      if (wait_r >= (slow_i ? 3'h5 : 3'h0)) begin
        nv_done_o <= 1'b1;
        nv_blank_o <= 1'b0;
        nv_rate_o <= nv_wdata_i;
        wait_r <= 3'h0;
      end
    end
  end
endmodule : pwl_nv_model
`default_nettype wire

// ---- verilog/pwl_ahb_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwl_ahb_slave
  import pwl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // address phase qualifiers
  input wire logic acc_i,
  input wire logic write_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] rdata_i,
  // bus answer
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic [1:0] hresp_o,
  // data phase write strobe
  output logic wr_en_o,
  output logic [7:0] wr_addr_o
);
  // read data is captured at the end of the address phase, so no wait state is needed
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hrdata_o <= '0;
      hreadyout_o <= 1'b1;
      hresp_o <= HRESP_OKAY;
      wr_en_o <= 1'b0;
      wr_addr_o <= '0;
    end else begin
      hrdata_o <= (acc_i && !write_i) ? rdata_i : '0;
      hreadyout_o <= 1'b1;
      hresp_o <= HRESP_OKAY;
      wr_en_o <= acc_i && write_i;
      wr_addr_o <= addr_i;
    end
  end
endmodule : pwl_ahb_slave
`default_nettype wire

// ---- verilog/pwl_loader.sv ----
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pwl_loader
  import pwl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // rotary switches
  input wire logic [SW_W-1:0] sw_upper_i,
  input wire logic [SW_W-1:0] sw_lower_i,
  // nonvolatile store
  input wire logic nv_blank_i,
  input wire logic [RATE_W-1:0] nv_rate_i,
  input wire logic nv_done_i,
  output logic nv_wr_o,
  output logic [RATE_W-1:0] nv_wdata_o,
  // network interface unit configuration
  output logic [RATE_W-1:0] can_rate_o,
  output logic [ADDR_W-1:0] node_addr_o,
  output logic can_enable_o,
  output logic cfg_done_o,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic [1:0] hresp_o
);
  pwl_state_t state_r, state_nxt;
  logic dec_rate_mode, dec_rate_ok, dec_addr_ok;
  logic [RATE_W-1:0] dec_rate;
  logic [ADDR_W-1:0] dec_addr;
  logic [SW_W-1:0] snap_upper_r, snap_lower_r;
  logic snap_rate_mode_r, snap_rate_ok_r, snap_addr_ok_r;
  logic [RATE_W-1:0] snap_rate_r;
  logic [ADDR_W-1:0] snap_addr_r;
  logic [RATE_W-1:0] stored_rate;
  logic need_write;
  logic [31:0] ctrl_r;
  logic nv_wrote_r, rate_kept_r;
  logic nv_wr_r;
  logic [RATE_W-1:0] nv_wdata_r;
  logic [RATE_W-1:0] can_rate_r;
  logic [ADDR_W-1:0] node_addr_r;
  logic can_enable_r, cfg_done_r;
  logic bus_acc, bus_mapped, wr_en;
  logic [7:0] wr_addr;
  logic [31:0] rd_mux, sts_word, sw_word, cfg_word;

  // registered switch decode; both switches feed both results
  pwl_sw_decode u_dec (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .sw_upper_i(sw_upper_i),
    .sw_lower_i(sw_lower_i),
    .rate_mode_o(dec_rate_mode),
    .rate_sel_ok_o(dec_rate_ok),
    .rate_sel_o(dec_rate),
    .addr_o(dec_addr),
    .addr_ok_o(dec_addr_ok)
  );

  // a store that was never written stands for the factory rate
  assign stored_rate = nv_blank_i ? RATE_DEFAULT : nv_rate_i;
  // default is treated as a stored value, so choosing it on a blank store writes nothing
  assign need_write = snap_rate_mode_r && snap_rate_ok_r && ctrl_r[CTRL_WREN_BIT]
                      && (snap_rate_r != stored_rate);

  // power-up sequence: runs once per reset, then sits in run
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_BOOT: begin
        state_nxt = ST_LATCH; // decoder flops fill during this cycle
      end
      ST_LATCH: begin
        state_nxt = ST_CHECK;
      end
      ST_CHECK: begin
        state_nxt = need_write ? ST_WRITE : ST_RUN;
      end
      ST_WRITE: begin
        state_nxt = nv_done_i ? ST_RUN : ST_WRITE;
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= ST_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // snapshot taken once; later switch moves are never looked at
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      snap_upper_r <= '0;
      snap_lower_r <= '0;
      snap_rate_mode_r <= 1'b0;
      snap_rate_ok_r <= 1'b0;
      snap_rate_r <= RATE_DEFAULT;
      snap_addr_r <= '0;
      snap_addr_ok_r <= 1'b0;
    end else if (state_r == ST_LATCH) begin
      snap_upper_r <= sw_upper_i;
      snap_lower_r <= sw_lower_i;
      snap_rate_mode_r <= dec_rate_mode;
      snap_rate_ok_r <= dec_rate_ok;
      snap_rate_r <= dec_rate;
      snap_addr_r <= dec_addr;
      snap_addr_ok_r <= dec_addr_ok;
    end
  end

  // store write: request held until the memory reports completion
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nv_wr_r <= 1'b0;
      nv_wdata_r <= RATE_DEFAULT;
      nv_wrote_r <= 1'b0;
      rate_kept_r <= 1'b0;
    end else begin
      if (state_r == ST_CHECK) begin
        nv_wr_r <= need_write;
        nv_wdata_r <= snap_rate_r;
        rate_kept_r <= snap_rate_mode_r && !snap_rate_ok_r;
      end else if (state_r == ST_WRITE && nv_done_i) begin
        nv_wr_r <= 1'b0;
        nv_wrote_r <= 1'b1;
      end
    end
  end

  // configuration published to the controller once the sequence ends
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      can_rate_r <= RATE_DEFAULT;
      node_addr_r <= '0;
      can_enable_r <= 1'b0;
      cfg_done_r <= 1'b0;
    end else if (state_r != ST_RUN && state_nxt == ST_RUN) begin
      // a fresh selection is used at once, otherwise the stored rate
      can_rate_r <= need_write || (state_r == ST_WRITE) ? snap_rate_r : stored_rate;
      node_addr_r <= snap_addr_r;
      can_enable_r <= snap_addr_ok_r && !snap_rate_mode_r;
      cfg_done_r <= 1'b1;
    end
  end

  // bus access qualification, address bits 31:4 must be zero and the address word aligned
  assign bus_acc = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
  assign bus_mapped = (haddr_i[31:4] == 28'h0) && (haddr_i[1:0] == 2'h0);

  // read words; unused bits read zero
  assign sts_word = {22'h0, rate_kept_r, cfg_done_r, nv_wrote_r, can_enable_r,
                     snap_addr_ok_r, snap_rate_mode_r, 1'b0, 3'(state_r)};
  assign sw_word = {24'h0, snap_upper_r, snap_lower_r};
  assign cfg_word = {17'h0, node_addr_r, 5'h0, can_rate_r};
  // unmapped addresses read zero and ignore writes
  assign rd_mux = !bus_mapped ? 32'h0 :
                  (haddr_i[7:0] == REG_CTRL) ? ctrl_r :
                  (haddr_i[7:0] == REG_STATUS) ? sts_word :
                  (haddr_i[7:0] == REG_SWITCH) ? sw_word :
                  (haddr_i[7:0] == REG_CONFIG) ? cfg_word : 32'h0;

  pwl_ahb_slave u_bus (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .acc_i(bus_acc && bus_mapped),
    .write_i(hwrite_i),
    .addr_i(haddr_i[7:0]),
    .rdata_i(rd_mux),
    .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr)
  );

  // control: write enable gates the store; only bit zero is kept
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_en && wr_addr == REG_CTRL) begin
      ctrl_r <= {31'h0, hwdata_i[CTRL_WREN_BIT]};
    end
  end

  // outputs straight from flops
  assign nv_wr_o = nv_wr_r;
  assign nv_wdata_o = nv_wdata_r;
  assign can_rate_o = can_rate_r;
  assign node_addr_o = node_addr_r;
  assign can_enable_o = can_enable_r;
  assign cfg_done_o = cfg_done_r;
endmodule : pwl_loader
`default_nettype wire

// ---- verilog/pwl_sw_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module pwl_sw_decode
  import pwl_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // raw switch positions
  input wire logic [SW_W-1:0] sw_upper_i,
  input wire logic [SW_W-1:0] sw_lower_i,
  // decoded view, registered
  output logic rate_mode_o,
  output logic rate_sel_ok_o,
  output logic [RATE_W-1:0] rate_sel_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_ok_o
);
  logic [7:0] addr_full;
  logic rate_mode;

  // lower positions above nine are the unmarked rate positions
  assign rate_mode = (sw_lower_i > LOWER_DIGIT_MAX);
  assign addr_full = pwl_node_addr(sw_upper_i, sw_lower_i);

  // decode is registered so the sequencer sees stable values
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rate_mode_o <= 1'b0;
      rate_sel_ok_o <= 1'b0;
      rate_sel_o <= RATE_DEFAULT;
      addr_o <= '0;
      addr_ok_o <= 1'b0;
    end else begin
      rate_mode_o <= rate_mode;
      rate_sel_ok_o <= (sw_upper_i <= UPPER_RATE_MAX);
      rate_sel_o <= sw_upper_i[RATE_W-1:0];
      addr_o <= addr_full[ADDR_W-1:0];
      addr_ok_o <= !rate_mode && (addr_full >= ADDR_MIN) && (addr_full <= ADDR_MAX);
    end
  end
endmodule : pwl_sw_decode
`default_nettype wire
